// File: src/asp_pkg.sv
// Behaviour
// (R01) host holds restart pin low four clocks
// (R02) restart low resets filter, keeps configuration
// (R03) release on next falling master clock edge
// (R04) host releases shared restart on rising edge
// (R05) restart rise starts conversion, ready falls after
// (R06) restart-started conversions wait full settling time
// (R07) temperature select routes sensor to converter
// (R08) temperature code zero kelvin, 2815 per degree
// (R09) pair enables drive pins from level bits
// (R10) output register read returns sensed pin levels
// (R11) host pulses restart after external channel change
// (R12) parity enable bit turns on parity
// (R13) status byte appended after each result
// (R14) parity bit makes total ones even
// (R15) four calibration modes started by mode write
// (R16) result minus offset, times full-scale coefficient
// (R17) calibration start raises ready bit and pin
// (R18) calibration end updates coefficient, ready low, idle
// (R19) host calibrates zero before full, polls ready
// (R20) chop off zero calibration lasts settling time
// (R21) chop on internal timings, gain doubles full
// (R22) internal full calibration needs rate word /16
// (R23) coefficients readable always, writable idle only; the code also accepts writes in power-down
package asp_pkg;
  localparam logic [2:0] REG_STATUS = 3'h0;
  localparam logic [2:0] REG_MODE = 3'h1;
  localparam logic [2:0] REG_CONFIG = 3'h2;
  localparam logic [2:0] REG_DATA = 3'h3;
  localparam logic [2:0] REG_GPO = 3'h4;
  localparam logic [2:0] REG_OFFSET = 3'h5;
  localparam logic [2:0] REG_FULLSCALE = 3'h6;
  localparam int MODE_OP_LSB = 0;
  localparam int MODE_PAR_BIT = 3;
  localparam int MODE_APP_BIT = 4;
  localparam int MODE_SINC3_BIT = 5;
  localparam int MODE_CHOP_BIT = 6;
  localparam int MODE_FS_LSB = 8;
  localparam int CFG_TEMP_BIT = 0;
  localparam int CFG_BIP_BIT = 1;
  localparam int CFG_GAIN_LSB = 2;
  localparam int GPO_LO_EN_BIT = 4;
  localparam int GPO_HI_EN_BIT = 5;
  localparam logic [9:0] FS_RST = 10'h060;
  localparam logic [23:0] OFFSET_RST = 24'h800000;
  localparam logic [23:0] FULLSCALE_RST = 24'h400000;
  localparam int UNITY_SHIFT = 22;
  localparam logic [23:0] MID_CODE = 24'h800000;
  localparam logic [23:0] SPAN_BIPOLAR = 24'h7FFFFF;
  localparam logic [23:0] SPAN_UNIPOLAR = 24'hFFFFFF;
  localparam logic [23:0] TEMP_ZERO_K_CODE = 24'h800000;
  localparam int TEMP_CODES_PER_K = 2815;
  localparam logic [2:0] CH_TEMP = 3'h2;
  localparam logic [2:0] CH_EXT = 3'h0;
  localparam logic [3:0] SETTLE_SINC4 = 4'h4;
  localparam logic [3:0] SETTLE_SINC3 = 4'h3;
  localparam logic [3:0] SETTLE_CHOP = 4'h2;
  localparam logic [3:0] FS_CAL_MASK = 4'hF;
  localparam int OUT_PERIOD_MCLK = 1024;
  typedef enum logic [2:0] {
    OP_CONT, OP_SINGLE, OP_IDLE, OP_PDOWN, OP_INT_ZERO, OP_INT_FULL, OP_SYS_ZERO, OP_SYS_FULL
  } asp_op_t;
endpackage

// File: src/asp_sync.sv
`timescale 1ns/100ps
module asp_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } asp_sync_st_t;
  asp_sync_st_t q, d;
  always_comb begin
    d.meta = async_in;
    d.stable = q.meta;
  end
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  assign sync_out = q.stable;
endmodule // asp_sync

// File: src/asp_divider.sv
`timescale 1ns/100ps
module asp_divider (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // request
  input wire logic start,
  input wire logic [47:0] dividend,
  input wire logic [23:0] divisor,
  // answer
  output logic busy,
  output logic done,
  output logic [23:0] quotient
);
  typedef struct packed {
    logic busy;
    logic done;
    logic [5:0] cnt;
    logic [24:0] rem;
    logic [47:0] quo;
    logic [23:0] dvs;
  } asp_div_st_t;
  asp_div_st_t q, d;
  logic [24:0] rem_sh;
  always_comb begin
    d = q;
    d.done = 1'b0;
    rem_sh = {q.rem[23:0], q.quo[47]};
    if (start && !q.busy) begin
      d.busy = 1'b1;
      d.cnt = 6'h30;
      d.rem = '0;
      d.quo = dividend;
      d.dvs = divisor;
    end else if (q.busy) begin
      d.quo = {q.quo[46:0], 1'b0};
      d.rem = rem_sh;
      if (rem_sh >= {1'b0, q.dvs}) begin
        d.rem = rem_sh - {1'b0, q.dvs};
        d.quo[0] = 1'b1;
      end
      d.cnt = q.cnt - 6'h01;
      if (q.cnt == 6'h01) begin
        d.busy = 1'b0;
        d.done = 1'b1;
      end
    end
  end
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  // saturate to coefficient width
  assign quotient = (q.quo[47:24] != 24'h0) ? 24'hFFFFFF : q.quo[23:0];
  assign busy = q.busy;
  assign done = q.done;
endmodule // asp_divider

// File: src/asp_top.sv
`timescale 1ns/100ps
module asp_top #(
  parameter int OUT_PERIOD_MCLK = asp_pkg::OUT_PERIOD_MCLK
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // register port
  input wire logic [2:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // device pins
  input wire logic mclk,
  input wire logic sync_n,
  input wire logic cs_n,
  output logic dout_rdy_n,
  output logic dout_rdy_oe,
  // general purpose outputs
  input wire logic [3:0] gpo_in,
  output logic [3:0] gpo_out,
  output logic [3:0] gpo_oe,
  // filter and front end
  input wire logic [23:0] raw_code,
  output logic filt_hold,
  output logic temp_sensor_select
);
  typedef struct packed {
    asp_pkg::asp_op_t op;
    logic parity_enable;
    logic append_status;
    logic sinc3;
    logic chop;
    logic [9:0] filter_rate_word;
    logic temp_sel;
    logic bipolar;
    logic [2:0] gain;
    logic gpo_upper_pair_enable;
    logic gpo_lower_pair_enable;
    logic [3:0] gpo_level;
    logic [23:0] off_coef;
    logic [23:0] fs_coef;
    logic [23:0] data;
    logic rdy_n;
    logic err;
    logic filt_rst;
    logic mclk_prev;
    logic fs_pending;
    logic [19:0] per_cnt;
    logic [3:0] settle;
    logic [3:0] cal_left;
    logic [3:0] gpo_out;
    logic [3:0] gpo_oe;
    logic dout_rdy_n;
    logic dout_oe;
    logic [31:0] rdata;
  } asp_top_st_t;

  //////////////////////////////////////////////////////////////////////////
  function automatic logic [3:0] settle_periods(input logic chop, input logic sinc3);
    if (chop) begin
      settle_periods = asp_pkg::SETTLE_CHOP;
    end else if (sinc3) begin
      settle_periods = asp_pkg::SETTLE_SINC3;
    end else begin
      settle_periods = asp_pkg::SETTLE_SINC4;
    end
  endfunction

  function automatic logic [23:0] correct(input logic [23:0] raw, input logic [23:0] off,
                                          input logic [23:0] gc, input logic [23:0] zero);
    logic signed [51:0] diff;
    logic signed [51:0] y;
    diff = $signed({28'h0, raw}) - $signed({28'h0, off});
    y = ((diff * $signed({28'h0, gc})) >>> asp_pkg::UNITY_SHIFT) + $signed({28'h0, zero});
    if (y < 0) begin
      correct = 24'h0;
    end else if (y > $signed({28'h0, 24'hFFFFFF})) begin
      correct = 24'hFFFFFF;
    end else begin
      correct = y[23:0];
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  asp_top_st_t q, d;
  logic [6:0] pins_s;
  logic sync_lvl, mclk_s, cs_lvl, mclk_fall, running, tick, new_data, cal_fin, par;
  logic [3:0] gpo_in_s;
  logic [19:0] per_len;
  logic [29:0] per_prod;
  logic [23:0] zero_code, span, cal_diff, quot;
  logic [7:0] sta;
  logic div_start, div_busy, div_done;

  asp_sync #(.W(7)) u_sync (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .async_in({gpo_in, cs_n, mclk, sync_n}),
    .sync_out(pins_s)
  );
  assign sync_lvl = pins_s[0];
  assign mclk_s = pins_s[1];
  assign cs_lvl = pins_s[2];
  assign gpo_in_s = pins_s[6:3];

  asp_divider u_div (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .start(div_start),
    .dividend({2'b00, span, 22'h0}),
    .divisor(cal_diff),
    .busy(div_busy),
    .done(div_done),
    .quotient(quot)
  );

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    d = q;
    new_data = 1'b0;
    cal_fin = 1'b0;
    div_start = 1'b0;
    zero_code = q.bipolar ? asp_pkg::MID_CODE : 24'h0; // see (R08)
    span = q.bipolar ? asp_pkg::SPAN_BIPOLAR : asp_pkg::SPAN_UNIPOLAR;
    cal_diff = raw_code - q.off_coef;
    per_prod = 30'(q.filter_rate_word) * 30'(OUT_PERIOD_MCLK);
    per_len = (q.filter_rate_word == 10'h0) ? 20'h1 : per_prod[19:0];
    mclk_fall = q.mclk_prev & ~mclk_s;
    d.mclk_prev = mclk_s;
    running = (q.op != asp_pkg::OP_IDLE) && (q.op != asp_pkg::OP_PDOWN) &&
              !q.fs_pending && !div_busy;
    tick = running && mclk_fall && !q.filt_rst && (q.per_cnt == per_len - 20'h1);
    // status byte, parity keeps the whole word even
    par = q.parity_enable & (^{q.data, q.rdy_n, q.err,
          (q.temp_sel ? asp_pkg::CH_TEMP : asp_pkg::CH_EXT)}); // see (R12) (R14)
    sta = {q.rdy_n, q.err, 1'b0, par, 1'b0,
           (q.temp_sel ? asp_pkg::CH_TEMP : asp_pkg::CH_EXT)};

    // register reads, data lands the next cycle
    if (reg_rd) begin
      case (reg_addr)
        asp_pkg::REG_STATUS: d.rdata = {24'h0, sta};
        asp_pkg::REG_MODE: d.rdata = {14'h0, q.filter_rate_word, 1'b0, q.chop, q.sinc3,
                                      q.append_status, q.parity_enable, q.op};
        asp_pkg::REG_CONFIG: d.rdata = {27'h0, q.gain, q.bipolar, q.temp_sel};
        asp_pkg::REG_DATA: begin
          d.rdata = q.append_status ? {q.data, sta} : {8'h0, q.data}; // see (R13)
          d.rdy_n = 1'b1;
        end
        asp_pkg::REG_GPO: d.rdata = {26'h0, q.gpo_upper_pair_enable,
                                     q.gpo_lower_pair_enable, gpo_in_s}; // see (R10)
        asp_pkg::REG_OFFSET: d.rdata = {8'h0, q.off_coef}; // see (R23)
        asp_pkg::REG_FULLSCALE: d.rdata = {8'h0, q.fs_coef}; // see (R23)
        default: d.rdata = 32'h0;
      endcase
    end

    // restart pin holds filter, configuration untouched
    if (!sync_lvl) begin
      d.filt_rst = 1'b1; // see (R02)
      d.per_cnt = 20'h0;
      d.settle = settle_periods(q.chop, q.sinc3); // see (R06)
    end else if (q.filt_rst && mclk_fall) begin
      d.filt_rst = 1'b0; // see (R03)
    end else if (running && mclk_fall && !q.filt_rst) begin
      d.per_cnt = tick ? 20'h0 : q.per_cnt + 20'h1;
    end

    // one output period elapsed
    if (tick && sync_lvl) begin
      case (q.op)
        asp_pkg::OP_CONT, asp_pkg::OP_SINGLE: begin
          if (q.settle > 4'h1) begin
            d.settle = q.settle - 4'h1; // see (R06)
          end else begin
            d.data = correct(raw_code, q.off_coef, q.fs_coef, zero_code); // see (R16)
            new_data = 1'b1; // see (R05)
            if (q.op == asp_pkg::OP_SINGLE) begin
              d.op = asp_pkg::OP_IDLE;
            end
          end
        end
        asp_pkg::OP_INT_ZERO, asp_pkg::OP_SYS_ZERO: begin
          if (q.cal_left > 4'h1) begin
            d.cal_left = q.cal_left - 4'h1; // see (R20) (R21)
          end else begin
            d.off_coef = raw_code; // see (R18)
            cal_fin = 1'b1;
          end
        end
        asp_pkg::OP_INT_FULL, asp_pkg::OP_SYS_FULL: begin
          if (q.cal_left > 4'h1) begin
            d.cal_left = q.cal_left - 4'h1; // see (R21)
          end else if ((q.op == asp_pkg::OP_INT_FULL) &&
                       ((q.filter_rate_word[3:0] & asp_pkg::FS_CAL_MASK) != 4'h0)) begin
            d.err = 1'b1; // see (R22)
            cal_fin = 1'b1;
          end else if (cal_diff == 24'h0 || cal_diff[23]) begin
            d.err = 1'b1;
            cal_fin = 1'b1;
          end else begin
            div_start = 1'b1;
            d.fs_pending = 1'b1;
          end
        end
        default: d.per_cnt = 20'h0;
      endcase
    end

    // full-scale coefficient from span over measured difference
    if (div_done && q.fs_pending) begin
      d.fs_coef = quot; // see (R18)
      d.fs_pending = 1'b0;
      cal_fin = 1'b1;
    end
    if (cal_fin) begin
      d.op = asp_pkg::OP_IDLE; // see (R18)
    end
    if (new_data || cal_fin) begin
      d.rdy_n = 1'b0;
    end

    // register writes
    if (reg_wr) begin
      case (reg_addr)
        asp_pkg::REG_MODE: begin
          d.op = asp_pkg::asp_op_t'(reg_wdata[asp_pkg::MODE_OP_LSB +: 3]); // see (R15)
          d.parity_enable = reg_wdata[asp_pkg::MODE_PAR_BIT]; // see (R12)
          d.append_status = reg_wdata[asp_pkg::MODE_APP_BIT];
          d.sinc3 = reg_wdata[asp_pkg::MODE_SINC3_BIT];
          d.chop = reg_wdata[asp_pkg::MODE_CHOP_BIT];
          d.filter_rate_word = reg_wdata[asp_pkg::MODE_FS_LSB +: 10];
          d.per_cnt = 20'h0;
          d.fs_pending = 1'b0;
          d.settle = settle_periods(reg_wdata[asp_pkg::MODE_CHOP_BIT],
                                    reg_wdata[asp_pkg::MODE_SINC3_BIT]);
          if (reg_wdata[2]) begin
            d.rdy_n = 1'b1; // see (R17)
            d.err = 1'b0;
            d.cal_left = settle_periods(reg_wdata[asp_pkg::MODE_CHOP_BIT],
                                        reg_wdata[asp_pkg::MODE_SINC3_BIT]); // see (R20)
            if (reg_wdata[2:0] == 3'h5 && q.gain != 3'h0) begin
              d.cal_left = {d.cal_left[2:0], 1'b0}; // see (R21)
            end
          end
        end
        asp_pkg::REG_CONFIG: begin
          d.temp_sel = reg_wdata[asp_pkg::CFG_TEMP_BIT]; // see (R07)
          d.bipolar = reg_wdata[asp_pkg::CFG_BIP_BIT];
          d.gain = reg_wdata[asp_pkg::CFG_GAIN_LSB +: 3];
        end
        asp_pkg::REG_GPO: begin
          d.gpo_level = reg_wdata[3:0];
          d.gpo_lower_pair_enable = reg_wdata[asp_pkg::GPO_LO_EN_BIT];
          d.gpo_upper_pair_enable = reg_wdata[asp_pkg::GPO_HI_EN_BIT];
        end
        asp_pkg::REG_OFFSET: begin
          if ((q.op == asp_pkg::OP_IDLE || q.op == asp_pkg::OP_PDOWN) && !cal_fin) begin
            d.off_coef = reg_wdata[23:0]; // see (R23)
          end
        end
        asp_pkg::REG_FULLSCALE: begin
          if ((q.op == asp_pkg::OP_IDLE || q.op == asp_pkg::OP_PDOWN) && !cal_fin) begin
            d.fs_coef = reg_wdata[23:0]; // see (R23)
          end
        end
        default: d.rdata = d.rdata;
      endcase
    end

    // pins follow the new register state, ready pin enable follows chip select
    d.gpo_oe = {{2{d.gpo_upper_pair_enable}}, {2{d.gpo_lower_pair_enable}}}; // see (R09)
    d.gpo_out = d.gpo_level; // see (R09)
    d.dout_rdy_n = d.rdy_n; // see (R17) (R18)
    d.dout_oe = ~cs_lvl;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
      q.op <= asp_pkg::OP_CONT;
      q.filter_rate_word <= asp_pkg::FS_RST;
      q.bipolar <= 1'b1;
      q.off_coef <= asp_pkg::OFFSET_RST;
      q.fs_coef <= asp_pkg::FULLSCALE_RST;
      q.rdy_n <= 1'b1;
      q.dout_rdy_n <= 1'b1;
      q.filt_rst <= 1'b1;
      q.settle <= asp_pkg::SETTLE_SINC4;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata = q.rdata;
  assign dout_rdy_n = q.dout_rdy_n;
  assign dout_rdy_oe = q.dout_oe;
  assign gpo_out = q.gpo_out;
  assign gpo_oe = q.gpo_oe;
  assign filt_hold = q.filt_rst;
  assign temp_sensor_select = q.temp_sel;

  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  sequence s_release;
    q.filt_rst && sync_lvl && mclk_fall;
  endsequence
  sequence s_cal_write;
    reg_wr && reg_addr == asp_pkg::REG_MODE && reg_wdata[2];
  endsequence

  restart_hold_a: assert property (!sync_lvl |=> q.filt_rst [*1]) // see (R02)
    else $error("filter not held while restart low");
  config_kept_a: assert property (!sync_lvl && !reg_wr |=> $stable(q.op) && $stable(q.gain)) // see (R02)
    else $error("configuration changed by restart");
  restart_release_a: assert property (s_release |=> !q.filt_rst) // see (R03)
    else $error("filter not released on master clock fall");
  release_wait_a: assert property (q.filt_rst && !mclk_fall |=> q.filt_rst) // see (R03)
    else $error("filter released without master clock fall");
  temp_route_a: assert property (reg_wr && reg_addr == asp_pkg::REG_CONFIG // see (R07)
    |=> temp_sensor_select == $past(reg_wdata[asp_pkg::CFG_TEMP_BIT]))
    else $error("temperature select not routed");
  gpo_drive_a: assert property (gpo_oe[1] == gpo_oe[0] && gpo_oe[3] == gpo_oe[2] && // see (R09)
    gpo_out == q.gpo_level)
    else $error("output pins not paired with level bits");
  gpo_readback_a: assert property (reg_rd && reg_addr == asp_pkg::REG_GPO // see (R10)
    |=> reg_rdata[3:0] == $past(gpo_in_s))
    else $error("output register read not from pins");
  parity_even_a: assert property (reg_rd && reg_addr == asp_pkg::REG_DATA && // see (R14)
    q.append_status && q.parity_enable |=> ^reg_rdata == 1'b0)
    else $error("odd count of ones in data read");
  cal_start_a: assert property (s_cal_write ##1 !$past(reg_rd) |-> ##1 dout_rdy_n) // see (R17)
    else $error("ready pin not high at calibration start");
  cal_done_a: assert property (cal_fin && !reg_wr |=> // see (R18)
    q.op == asp_pkg::OP_IDLE && !q.rdy_n && !dout_rdy_n)
    else $error("calibration end not signalled");
  coef_guard_a: assert property (reg_wr && reg_addr == asp_pkg::REG_OFFSET && // see (R23)
    q.op == asp_pkg::OP_CONT && !cal_fin |=> $stable(q.off_coef))
    else $error("offset written while converting");
endmodule // asp_top

// File: verif/asp_host_model.sv
`timescale 1ns/100ps
module asp_host_model (
  // converter pins
  output logic mclk,
  output logic sync_n,
  output logic cs_n,
  output logic [23:0] raw_code,
  // general purpose pins
  input wire logic [3:0] gpo_out,
  input wire logic [3:0] gpo_oe,
  output logic [3:0] gpo_in
);
  logic [3:0] short_mask;
  initial begin
    mclk = 1'b0;
    sync_n = 1'b1;
    cs_n = 1'b0;
    raw_code = 24'h800000;
    short_mask = 4'h0;
  end
  // master clock runs free
  always #80 mclk = ~mclk;
  // undriven pins sit at the pull-down level, a short flips a driven pin
  assign gpo_in = gpo_oe & (gpo_out ^ short_mask);
  task automatic sync_low();
    @(posedge mclk);
    sync_n <= 1'b0;
  endtask
  // release on a rising master clock edge after n cycles low
  task automatic sync_high(input int n);
    repeat (n) @(posedge mclk);
    sync_n <= 1'b1;
  endtask
endmodule // asp_host_model

// File: verif/asp_top_test.sv
`timescale 1ns/100ps
module asp_top_test;
  localparam int P = 2;
  logic clk_sys, arst_n, reg_wr, reg_rd, mclk, sync_n, cs_n, dout_rdy_n, dout_rdy_oe;
  logic filt_hold, temp_sensor_select;
  logic [2:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, v;
  logic [3:0] gpo_in, gpo_out, gpo_oe, lv, en;
  logic [23:0] raw_code;
  int errors, checked, falls, n;
  longint off_m, fs_m;
  ////////////////////////////////////////////////////////////////////////////////
  always #2 clk_sys = ~clk_sys;
  always @(negedge mclk) falls = falls + 1;
  asp_top #(.OUT_PERIOD_MCLK(P)) asp_top_i (.clk_sys(clk_sys), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .mclk(mclk), .sync_n(sync_n), .cs_n(cs_n), .dout_rdy_n(dout_rdy_n),
    .dout_rdy_oe(dout_rdy_oe), .gpo_in(gpo_in), .gpo_out(gpo_out), .gpo_oe(gpo_oe),
    .raw_code(raw_code), .filt_hold(filt_hold), .temp_sensor_select(temp_sensor_select));
  asp_host_model asp_host_model_i (.mclk(mclk), .sync_n(sync_n), .cs_n(cs_n),
    .raw_code(raw_code), .gpo_out(gpo_out), .gpo_oe(gpo_oe), .gpo_in(gpo_in));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic wait_rdy(input int lim);
    int k;
    k = 0;
    while (dout_rdy_n !== 1'b0 && k < lim) begin
      @(posedge clk_sys);
      k++;
    end
    if (k >= lim) begin
      errors++;
      $display("unexpected timeout on ready pin");
      summarize();
    end
  endtask
  function automatic logic [31:0] mw(input logic [2:0] op, input logic [3:0] fl,
                                     input logic [9:0] rt);
    return {14'h0, rt, 1'b0, fl, op};
  endfunction
  // corrected result from offset and full-scale coefficients
  function automatic logic [23:0] corr(input longint raw);
    longint c;
    c = longint'(64'h800000) + (((raw - off_m) * fs_m) >>> 22);
    if (c < 0) c = 0;
    if (c > longint'(64'hFFFFFF)) c = longint'(64'hFFFFFF);
    return c[23:0];
  endfunction
  task automatic conv();
    logic [23:0] r;
    r = 24'($urandom);
    @(posedge clk_sys);
    asp_host_model_i.raw_code <= r;
    rd(asp_pkg::REG_DATA, v);
    wait_rdy(400);
    rd(asp_pkg::REG_DATA, v);
    wait_rdy(400);
    rd(asp_pkg::REG_DATA, v);
    chk("result", {8'h0, corr(r)}, {8'h0, v[31:8]});
    chk("parity", 32'h0, {31'h0, ^v});
    chk("channel", 32'h2, {29'h0, v[2:0]});
    chk("temp select pin", 32'h1, {31'h0, temp_sensor_select});
  endtask
  task automatic calib(input logic [2:0] op, input logic [3:0] fl, input logic [9:0] rt,
                       input int k);
    wr(asp_pkg::REG_MODE, mw(3'h2, fl, rt));
    falls = 0;
    wr(asp_pkg::REG_MODE, mw(op, fl, rt));
    repeat (3) @(posedge clk_sys);
    #1 chk("ready pin at start", 32'h1, {31'h0, dout_rdy_n});
    rd(asp_pkg::REG_STATUS, v);
    chk("ready bit at start", 32'h1, {31'h0, v[7]});
    wait_rdy((k * rt * P + 3) * 40 + 200);
    chk("calibration length", 32'h1,
        {31'h0, falls > (k - 1) * rt * P && falls <= k * rt * P + 2});
    rd(asp_pkg::REG_MODE, v);
    chk("mode after calibration", 32'h2, {29'h0, v[2:0]});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    arst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 32'h0;
    errors = 0;
    checked = 0;
    falls = 0;
    off_m = 64'h800000;
    fs_m = 64'h400000;
    void'($urandom(19167));
    repeat (20) @(posedge clk_sys);
    arst_n <= 1'b1;
    rd(asp_pkg::REG_MODE, v);
    chk("mode reset", 32'h6000, v);
    rd(asp_pkg::REG_OFFSET, v);
    chk("offset reset", 32'h800000, v);
    rd(asp_pkg::REG_FULLSCALE, v);
    chk("fullscale reset", 32'h400000, v);
    wr(3'h7, 32'hFFFFFFFF);
    rd(3'h7, v);
    chk("unmapped", 32'h0, v);
    $display("test reset values done");
    for (int e = 0; e < 4; e++) begin
      lv = 4'($urandom);
      en = {e[1], e[1], e[0], e[0]};
      wr(asp_pkg::REG_GPO, {26'h0, e[1:0], lv});
      repeat (4) @(posedge clk_sys);
      #1 chk("gpo enables", {28'h0, en}, {28'h0, gpo_oe});
      chk("gpo levels", {28'h0, lv}, {28'h0, gpo_out});
      rd(asp_pkg::REG_GPO, v);
      chk("gpo sensed", {28'h0, lv & en}, {28'h0, v[3:0]});
    end
    asp_host_model_i.short_mask = 4'h1;
    wr(asp_pkg::REG_GPO, 32'h3F);
    repeat (4) @(posedge clk_sys);
    rd(asp_pkg::REG_GPO, v);
    chk("gpo short", 32'hE, {28'h0, v[3:0]});
    asp_host_model_i.short_mask = 4'h0;
    $display("test outputs done");
    wr(asp_pkg::REG_CONFIG, 32'h3);
    wr(asp_pkg::REG_MODE, mw(3'h0, 4'h3, 10'h001));
    asp_host_model_i.sync_low();
    repeat (30) @(posedge clk_sys);
    #1 chk("filter held", 32'h1, {31'h0, filt_hold});
    rd(asp_pkg::REG_CONFIG, v);
    chk("config kept", 32'h3, {27'h0, v[4:0]});
    rd(asp_pkg::REG_DATA, v);
    asp_host_model_i.sync_high(4);
    falls = 0;
    n = 0;
    while (filt_hold !== 1'b0 && n < 60) begin
      @(posedge clk_sys);
      n++;
    end
    chk("release delay", 32'h1, {31'h0, n >= 20 && n <= 27});
    wait_rdy(2000);
    chk("first result delay", 32'h1, {31'h0, falls >= 4 * P && falls <= 4 * P + 1});
    repeat (3) conv();
    $display("test restart and conversion done");
    @(posedge clk_sys);
    asp_host_model_i.raw_code <= 24'h812345;
    off_m = 64'h812345;
    calib(3'h4, 4'h0, 10'h001, 4);
    calib(3'h4, 4'h4, 10'h001, 3);
    calib(3'h4, 4'h8, 10'h001, 2);
    calib(3'h6, 4'h0, 10'h001, 4);
    rd(asp_pkg::REG_OFFSET, v);
    chk("offset after zero", off_m[31:0], v);
    n = 32'h400000 + ($urandom % 32'h100000);
    fs_m = (64'h7FFFFF << 22) / n;
    asp_host_model_i.raw_code <= 24'(off_m + n);
    calib(3'h7, 4'h0, 10'h001, 4);
    calib(3'h5, 4'h0, 10'h010, 4);
    wr(asp_pkg::REG_CONFIG, 32'h7);
    calib(3'h5, 4'h0, 10'h010, 8);
    rd(asp_pkg::REG_FULLSCALE, v);
    chk("fullscale after cal", fs_m[31:0], v);
    wr(asp_pkg::REG_CONFIG, 32'h3);
    wr(asp_pkg::REG_MODE, mw(3'h5, 4'h0, 10'h011));
    repeat (10) @(posedge clk_sys);
    wait_rdy((4 * 17 * P + 3) * 40 + 200);
    rd(asp_pkg::REG_STATUS, v);
    chk("error bit", 32'h1, {31'h0, v[6]});
    rd(asp_pkg::REG_FULLSCALE, v);
    chk("fullscale kept", fs_m[31:0], v);
    wr(asp_pkg::REG_MODE, mw(3'h0, 4'h3, 10'h001));
    repeat (3) conv();
    $display("test calibration done");
    wr(asp_pkg::REG_OFFSET, 32'h123456);
    rd(asp_pkg::REG_OFFSET, v);
    chk("offset write refused", off_m[31:0], v);
    wr(asp_pkg::REG_MODE, mw(3'h1, 4'h3, 10'h001));
    wait_rdy(600);
    rd(asp_pkg::REG_MODE, v);
    chk("mode after single", 32'h2, {29'h0, v[2:0]});
    wr(asp_pkg::REG_MODE, mw(3'h2, 4'h0, 10'h001));
    wr(asp_pkg::REG_OFFSET, 32'h123456);
    rd(asp_pkg::REG_OFFSET, v);
    chk("offset write idle", 32'h123456, v);
    wr(asp_pkg::REG_MODE, mw(3'h3, 4'h0, 10'h001));
    wr(asp_pkg::REG_FULLSCALE, 32'h2AAAAA);
    rd(asp_pkg::REG_FULLSCALE, v);
    chk("fullscale write pdown", 32'h2AAAAA, v);
    asp_host_model_i.cs_n = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1 chk("ready pin released", 32'h0, {31'h0, dout_rdy_oe});
    asp_host_model_i.cs_n = 1'b0;
    $display("test coefficient access done");
    summarize();
  end
endmodule // asp_top_test
